// ==== rtl/ocs_pkg.sv ====
package ocs_pkg;
   // register map on the plain register port
   localparam logic [1:0] OCS_ADDR_STATUS = 2'h0;
   localparam logic [1:0] OCS_ADDR_TRIM = 2'h1;
   localparam logic [1:0] OCS_ADDR_CONFIG = 2'h2;
   localparam logic [1:0] OCS_ADDR_RECOVERY = 2'h3;
   // status register fields
   localparam int OCS_BIT_GEN_EN = 1;
   localparam int OCS_BIT_ENGAGED = 0;
   // config register fields (source select, short stop recovery)
   localparam int OCS_BIT_SEL_LO = 0;
   localparam int OCS_BIT_SEL_HI = 1;
   localparam int OCS_BIT_SHORT_REC = 2;
   localparam logic [7:0] OCS_TRIM_RESET = 8'h80;
   // untrimmed internal oscillator 12.8 MHz, bus 3.2 MHz at this trim
   localparam int OCS_NOMINAL_KHZ = 12800;
   localparam logic [12:0] OCS_REC_LONG = 13'h1000;
   localparam logic [12:0] OCS_REC_SHORT = 13'h0020;
   // external clock edges counted before it is engaged; the engage happens on the edge after that
   localparam logic [3:0] OCS_EXT_STABLE = 4'hF;
   localparam logic [1:0] OCS_SEL_INTERNAL = 2'h0;
   localparam logic [1:0] OCS_SEL_EXT_OSC = 2'h1;
   localparam logic [1:0] OCS_SEL_EXT_RC = 2'h2;
   localparam logic [1:0] OCS_SEL_CRYSTAL = 2'h3;

   typedef enum logic [1:0] {
      OCS_RUN = 2'b00,
      OCS_STOPPED = 2'b01,
      OCS_RECOVER = 2'b10
   } ocs_state_t;

   typedef struct packed {
      ocs_state_t st;
      logic [1:0] sel;
      logic short_rec;
      logic gen_en;
      logic engaged;
      logic [3:0] stable_cnt;
      logic ext_prev;
      logic [7:0] trim;
      logic [12:0] rec_cnt;
      logic [1:0] div;
      logic x2;
      logic x4_en;
      logic [7:0] rdata;
   } ocs_regs_t;
endpackage

// ==== rtl/ocs_clock_control.sv ====
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// RULE1 - bus clock is one quarter of the selected source clock
// RULE2 - wait mode leaves oscillator logic and both system clocks running
// RULE3 - stop instruction disables source output, stopping both derived clocks
// RULE4 - break state keeps both system clocks running without interruption
// RULE5 - two-bit select: 00 internal, 01 ext oscillator, 10 RC, 11 crystal
// RULE6 - generator enable bit set to 1 starts switch to external source
// RULE7 - generator enable bit held at 0 during reset
// RULE8 - generator enable ignored in bypassed monitor mode and both test modes
// RULE9 - engaged status reads 1 only while external source drives system clock
// RULE10 - 8-bit trim adjusts internal oscillator period, 0.2 percent per step
// RULE11 - trim resets to 80 hex, nominal 12.8 MHz, bus 3.2 MHz
// RULE12 - software should copy factory trim byte into trim register
// RULE13 - fourfold system clock runs at the selected source frequency
// RULE14 - stop recovery lasts 4096 cycles, or 32 with short recovery set
// RULE15 - switch to external is glitch-free; engaged only once stable
module ocs_clock_control
   import ocs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ext_clock_level,
   input wire logic stop_req,
   input wire logic wake_req,
   input wire logic wait_mode,
   input wire logic break_state,
   input wire logic monitor_bypass,
   input wire logic production_test_mode_a,
   input wire logic production_test_mode_b,
   output logic sys_clock_x4_en,
   output logic sys_clock_x2,
   output logic bus_clock_en,
   output logic [7:0] internal_trim_factor,
   output logic ext_generator_enable,
   output logic ext_clock_engaged,
   output logic [1:0] source_select,
   output logic stop_recovering
);

   ocs_regs_t r_q;
   ocs_regs_t r_d;

   // generator enable is masked in bypassed monitor and test modes
   function automatic logic gen_effective(input logic en, input logic mon,
                                          input logic ta, input logic tb);
      gen_effective = en & ~mon & ~ta & ~tb;
   endfunction

   logic gen_on;
   assign gen_on = gen_effective(r_q.gen_en, monitor_bypass,
                                 production_test_mode_a, production_test_mode_b); // [RULE8]

   // next state: registers, stop sequencing, clock division, engage logic
   always_comb begin
      r_d = r_q;
      r_d.rdata = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            OCS_ADDR_STATUS: r_d.gen_en = reg_wdata[OCS_BIT_GEN_EN]; // [RULE6]
            OCS_ADDR_TRIM: r_d.trim = reg_wdata; // [RULE10] [RULE12]
            OCS_ADDR_CONFIG: begin
               r_d.sel = {reg_wdata[OCS_BIT_SEL_HI], reg_wdata[OCS_BIT_SEL_LO]}; // [RULE5]
               r_d.short_rec = reg_wdata[OCS_BIT_SHORT_REC];
            end
            default: r_d.gen_en = r_q.gen_en;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OCS_ADDR_STATUS: begin
               r_d.rdata[OCS_BIT_GEN_EN] = r_q.gen_en;
               r_d.rdata[OCS_BIT_ENGAGED] = r_q.engaged; // [RULE9]
            end
            OCS_ADDR_TRIM: r_d.rdata = r_q.trim;
            OCS_ADDR_CONFIG: begin
               r_d.rdata[OCS_BIT_SEL_HI] = r_q.sel[1];
               r_d.rdata[OCS_BIT_SEL_LO] = r_q.sel[0];
               r_d.rdata[OCS_BIT_SHORT_REC] = r_q.short_rec;
            end
            OCS_ADDR_RECOVERY: r_d.rdata = {7'h00, r_q.st == OCS_RECOVER};
            default: r_d.rdata = 8'h00;
         endcase
      end
      // engage only after the external clock is seen toggling steadily,
      // so the mux never switches onto a dead or starting clock
      r_d.ext_prev = ext_clock_level;
      if (!gen_on || r_q.sel == OCS_SEL_INTERNAL) begin
         r_d.stable_cnt = 4'h0;
         r_d.engaged = 1'b0; // [RULE9]
      end else if (ext_clock_level != r_q.ext_prev) begin
         if (r_q.stable_cnt == OCS_EXT_STABLE) begin
            r_d.engaged = 1'b1; // [RULE15]
         end else begin
            r_d.stable_cnt = r_q.stable_cnt + 4'h1;
         end
      end
      // wait and break have no effect here; only stop halts the clocks
      case (r_q.st)
         OCS_RUN: begin
            if (stop_req) begin
               r_d.st = OCS_STOPPED; // [RULE3]
            end
         end
         OCS_STOPPED: begin
            if (wake_req) begin
               r_d.st = OCS_RECOVER;
               r_d.rec_cnt = r_q.short_rec ? OCS_REC_SHORT : OCS_REC_LONG; // [RULE14]
            end
         end
         OCS_RECOVER: begin
            if (r_q.rec_cnt == 13'h0001) begin
               r_d.st = OCS_RUN;
            end
            r_d.rec_cnt = r_q.rec_cnt - 13'h0001;
         end
         default: r_d.st = OCS_RUN;
      endcase
      // x4 follows the source each cycle; x2 halves it; bus is a quarter
      r_d.x4_en = (r_d.st == OCS_RUN); // [RULE2] [RULE4] [RULE13]
      if (r_d.st == OCS_RUN) begin
         r_d.div = r_q.div + 2'h1; // [RULE1]
         r_d.x2 = ~r_q.x2;
      end
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q.st <= OCS_RUN;
         r_q.sel <= OCS_SEL_INTERNAL;
         r_q.short_rec <= 1'b0;
         r_q.gen_en <= 1'b0; // [RULE7]
         r_q.engaged <= 1'b0;
         r_q.stable_cnt <= 4'h0;
         r_q.ext_prev <= 1'b0;
         r_q.trim <= OCS_TRIM_RESET; // [RULE11]
         r_q.rec_cnt <= 13'h0000;
         r_q.div <= 2'h0;
         r_q.x2 <= 1'b0;
         r_q.x4_en <= 1'b1;
         r_q.rdata <= 8'h00;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   assign reg_rdata = r_q.rdata;
   assign sys_clock_x4_en = r_q.x4_en;
   assign sys_clock_x2 = r_q.x2;
   assign bus_clock_en = r_q.x4_en & (r_q.div == 2'h3); // [RULE1]
   assign internal_trim_factor = r_q.trim;
   assign ext_generator_enable = gen_on;
   assign ext_clock_engaged = r_q.engaged;
   assign source_select = r_q.sel;
   assign stop_recovering = (r_q.st == OCS_RECOVER);

   // reset values seen at the first edge after release
   a_trim_reset: assert property (@(posedge clk) $rose(arst_n) |-> r_q.trim == OCS_TRIM_RESET)
      else $error("trim not at reset value"); // [RULE11]
   a_gen_reset_low: assert property (@(posedge clk) // [RULE7]
      $rose(arst_n) |-> !ext_generator_enable)
      else $error("generator enable set out of reset");
   a_engaged_reset: assert property (@(posedge clk) // [RULE9]
      $rose(arst_n) |-> !ext_clock_engaged)
      else $error("engaged set out of reset");
   a_sel_reset: assert property (@(posedge clk) // [RULE5]
      $rose(arst_n) |-> source_select == OCS_SEL_INTERNAL)
      else $error("source select not internal after reset");
   a_x4_reset: assert property (@(posedge clk) // [RULE13]
      $rose(arst_n) |-> sys_clock_x4_en)
      else $error("fourfold clock not running after reset");
   // every mask on its own must hold the generator off
   a_gen_masked: assert property (@(posedge clk) disable iff (!arst_n)
      (monitor_bypass || production_test_mode_a || production_test_mode_b)
      |-> !ext_generator_enable)
      else $error("generator enable not masked"); // [RULE8]
   // with no mask present the register bit alone drives the generator
   a_gen_follows: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
      (!monitor_bypass && !production_test_mode_a && !production_test_mode_b)
      |-> ext_generator_enable == r_q.gen_en)
      else $error("generator enable does not follow its bit");
   // engaged must fall one edge after the source falls back to internal
   a_engaged_internal: assert property (@(posedge clk) disable iff (!arst_n) // [RULE9]
      (clk_en && source_select == OCS_SEL_INTERNAL) |=> !ext_clock_engaged)
      else $error("engaged while internal selected");
   // engaged must fall one edge after the generator is switched off or masked
   a_engaged_drop: assert property (@(posedge clk) disable iff (!arst_n) // [RULE9]
      (clk_en && !ext_generator_enable) |=> !ext_clock_engaged)
      else $error("engaged kept without generator");
   // engaging needs the full stability count and a live toggle
   a_engage_stable: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      $rose(ext_clock_engaged) |-> $past(r_q.stable_cnt) == OCS_EXT_STABLE)
      else $error("engaged before external clock stable");
   a_engage_toggle: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      $rose(ext_clock_engaged) |-> $past(ext_clock_level) != $past(r_q.ext_prev))
      else $error("engaged without an external edge");
   // read data is zero outside the cycle after a read strobe
   a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_read_trim: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      (clk_en && reg_rd && reg_addr == OCS_ADDR_TRIM) |=> reg_rdata == $past(r_q.trim))
      else $error("trim read back wrong");
   a_read_status: assert property (@(posedge clk) disable iff (!arst_n) // [RULE9]
      (clk_en && reg_rd && reg_addr == OCS_ADDR_STATUS)
      |=> reg_rdata[OCS_BIT_ENGAGED] == $past(r_q.engaged))
      else $error("engaged status read back wrong");
   a_read_config: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      (clk_en && reg_rd && reg_addr == OCS_ADDR_CONFIG)
      |=> reg_rdata[OCS_BIT_SHORT_REC] == $past(r_q.short_rec))
      else $error("short recovery bit read back wrong");
   // register writes land one edge after the strobe
   a_sel_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
      (clk_en && reg_wr && reg_addr == OCS_ADDR_CONFIG)
      |=> source_select == $past({reg_wdata[OCS_BIT_SEL_HI], reg_wdata[OCS_BIT_SEL_LO]}))
      else $error("source select not written");
   a_trim_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      (clk_en && reg_wr && reg_addr == OCS_ADDR_TRIM) |=> internal_trim_factor == $past(reg_wdata))
      else $error("trim not written");
   // trim must never move on its own, it sets the oscillator period
   a_trim_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      !(clk_en && reg_wr && reg_addr == OCS_ADDR_TRIM) |=> $stable(internal_trim_factor))
      else $error("trim changed without a write");
   // the twofold clock toggles on every running cycle, also in wait and break
   a_x2_toggles: assert property (@(posedge clk) disable iff (!arst_n) // [RULE2]
      (clk_en && r_q.st == OCS_RUN && !stop_req) |=> sys_clock_x2 != $past(sys_clock_x2))
      else $error("twofold clock not toggling");
   a_break_x2: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
      (clk_en && break_state && r_q.st == OCS_RUN && !stop_req)
      |=> sys_clock_x2 != $past(sys_clock_x2))
      else $error("twofold clock halted in break");
   // while stopped nothing derived from the source may move
   a_stopped_dark: assert property (@(posedge clk) disable iff (!arst_n) // [RULE3]
      r_q.st == OCS_STOPPED |-> !sys_clock_x4_en && !bus_clock_en)
      else $error("clocks running while stopped");
   a_x2_frozen: assert property (@(posedge clk) disable iff (!arst_n) // [RULE3]
      (clk_en && r_q.st == OCS_STOPPED) |=> $stable(sys_clock_x2))
      else $error("twofold clock moved while stopped");
   // the fourfold clock runs exactly while the state is run
   a_x4_run: assert property (@(posedge clk) disable iff (!arst_n) // [RULE13]
      (r_q.st == OCS_RUN) |-> sys_clock_x4_en)
      else $error("fourfold clock off while running");
   // recovery keeps the clocks dark and counts down one per cycle
   a_recover_dark: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      stop_recovering |-> !sys_clock_x4_en)
      else $error("clock running during recovery");
   a_recover_count: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      (clk_en && stop_recovering && r_q.rec_cnt != 13'h0001)
      |=> stop_recovering && r_q.rec_cnt == $past(r_q.rec_cnt) - 13'h0001)
      else $error("recovery count not stepping");
   a_recover_end: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      (clk_en && stop_recovering && r_q.rec_cnt == 13'h0001)
      |=> sys_clock_x4_en && !stop_recovering)
      else $error("recovery did not end on time");
   // a wake request outside stop must not disturb running clocks
   a_wake_ignored: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      (clk_en && r_q.st == OCS_RUN && wake_req && !stop_req) |=> r_q.st == OCS_RUN)
      else $error("wake request left run state");
   a_engaged_needs_gen: assert property (@(posedge clk) disable iff (!arst_n)
      ext_clock_engaged |-> $past(gen_on))
      else $error("engaged without generator"); // [RULE15]
   a_stop_halts: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && stop_req && r_q.st == OCS_RUN) |=> !sys_clock_x4_en)
      else $error("clocks not stopped"); // [RULE3]
   a_wait_runs: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && r_q.st == OCS_RUN && !stop_req && (wait_mode || break_state))
      |=> sys_clock_x4_en)
      else $error("clock stopped in wait or break"); // [RULE2]
   a_bus_quarter: assert property (@(posedge clk) disable iff (!arst_n)
      bus_clock_en && clk_en |=> !bus_clock_en)
      else $error("bus enable too frequent"); // [RULE1]
   a_short_rec: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && r_q.st == OCS_STOPPED && wake_req && r_q.short_rec)
      |=> r_q.rec_cnt == OCS_REC_SHORT)
      else $error("short recovery count wrong"); // [RULE14]
   a_long_rec: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && r_q.st == OCS_STOPPED && wake_req && !r_q.short_rec)
      |=> r_q.rec_cnt == OCS_REC_LONG)
      else $error("long recovery count wrong"); // [RULE14]
   a_gen_write: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en && reg_wr && reg_addr == OCS_ADDR_STATUS)
      |=> r_q.gen_en == $past(reg_wdata[OCS_BIT_GEN_EN]))
      else $error("generator enable not written"); // [RULE6]
endmodule

// ==== verification/ocs_ext_clock_model.sv ====
`timescale 1ns/1ps
module ocs_ext_clock_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic run,
   output logic ext_clock_level
);
   logic [1:0] ph_q;
   // external oscillator toggling every other cycle once the generator is on;
   // while off it never started, so the line sits still at its last level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_q <= 2'h0;
         ext_clock_level <= 1'b0;
      end else if (run) begin
         ph_q <= ph_q + 2'h1;
         if (ph_q[0]) ext_clock_level <= ~ext_clock_level;
      end
   end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import ocs_pkg::*;
   logic clk, arst_n, reg_wr, reg_rd, ext_clock_level, stop_req, wake_req, wait_mode;
   logic break_state, production_test_mode_a, sys_clock_x4_en, sys_clock_x2, bus_clock_en;
   logic ext_generator_enable, ext_clock_engaged, stop_recovering;
   logic monitor_bypass, production_test_mode_b;
   logic [1:0] reg_addr, source_select;
   logic [7:0] reg_wdata, reg_rdata, internal_trim_factor;
   int miscompares, samples_checked, n, m, k;
   // clk_en is held high; the freeze is not exercised here
   ocs_clock_control dut (.clk, .arst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ext_clock_level, .stop_req, .wake_req, .wait_mode, .break_state,
      .monitor_bypass, .production_test_mode_a, .production_test_mode_b,
      .sys_clock_x4_en, .sys_clock_x2, .bus_clock_en, .internal_trim_factor,
      .ext_generator_enable, .ext_clock_engaged, .source_select, .stop_recovering);
   ocs_ext_clock_model ext (.clk, .arst_n, .run(ext_generator_enable), .ext_clock_level);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(string name, logic [12:0] seen, logic [12:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(logic [1:0] a, logic [7:0] exp);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, exp);
   endtask
   // counts bus enables and fourfold enables over sixteen cycles
   task automatic count16;
      logic prev;
      n = 0;
      m = 0;
      k = 0;
      #1 prev = sys_clock_x2;
      repeat (16) begin
         @(posedge clk) #1 n += bus_clock_en;
         m += sys_clock_x4_en;
         k += (sys_clock_x2 != prev);
         prev = sys_clock_x2;
      end
   endtask
   task automatic t_regs;
      rd(OCS_ADDR_STATUS, 8'h00);
      rd(OCS_ADDR_TRIM, 8'h80);
      wr(OCS_ADDR_TRIM, 8'h5A);
      rd(OCS_ADDR_TRIM, 8'h5A);
      chk("trim_out", internal_trim_factor, 8'h5A);
      wr(OCS_ADDR_TRIM, OCS_TRIM_RESET); // factory byte copy
      $display("test registers done");
   endtask
   task automatic t_select;
      for (int i = 0; i < 4; i++) begin
         wr(OCS_ADDR_CONFIG, 8'(i));
         #1 chk("source_select", source_select, 13'(i));
      end
      @(posedge clk) {wait_mode, break_state} <= 2'b11;
      count16;
      chk("bus_en_count", 13'(n), 13'h4);
      chk("x4_count", 13'(m), 13'h10);
      chk("x2_toggles", 13'(k), 13'h10);
      @(posedge clk) {wait_mode, break_state} <= 2'b00;
      $display("test select done");
   endtask
   task automatic t_engage;
      wr(OCS_ADDR_CONFIG, 8'h01);
      wr(OCS_ADDR_STATUS, 8'h02);
      n = 0;
      while (ext_clock_engaged !== 1'b1 && n < 200) @(posedge clk) n++;
      rd(OCS_ADDR_STATUS, 8'h03);
      @(posedge clk) production_test_mode_a <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("gen_enable", ext_generator_enable, 1'b0);
      chk("engaged", ext_clock_engaged, 1'b0);
      @(posedge clk) production_test_mode_a <= 1'b0;
      monitor_bypass <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("gen_enable_mon", ext_generator_enable, 1'b0);
      @(posedge clk) monitor_bypass <= 1'b0;
      production_test_mode_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("gen_enable_tmb", ext_generator_enable, 1'b0);
      @(posedge clk) production_test_mode_b <= 1'b0;
      wr(OCS_ADDR_STATUS, 8'h00);
      $display("test engage done");
   endtask
   task automatic t_stop(logic short_rec, int exp);
      wr(OCS_ADDR_CONFIG, {5'h0, short_rec, 2'h0});
      @(posedge clk) stop_req <= 1'b1;
      @(posedge clk) stop_req <= 1'b0;
      #1 chk("x4_after_stop", sys_clock_x4_en, 1'b0);
      count16;
      chk("bus_en_stopped", 13'(n + m + k), 13'h0);
      @(posedge clk) wake_req <= 1'b1;
      @(posedge clk) wake_req <= 1'b0;
      #1 chk("recovering", stop_recovering, 1'b1);
      n = 0;
      #1 while (sys_clock_x4_en !== 1'b1 && n < 5000) @(posedge clk) #1 n++;
      chk("recovery_len", 13'((n >= exp - 1) && (n <= exp + 1)), 13'h1);
      $display("test stop done");
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      {reg_wr, reg_rd, stop_req, wake_req, wait_mode, break_state} = 6'h00;
      {production_test_mode_a, reg_addr, reg_wdata, arst_n} = 12'h000;
      {monitor_bypass, production_test_mode_b} = 2'h0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_regs;
      t_select;
      t_engage;
      t_stop(1'b1, 32);
      t_stop(1'b0, 4096);
      close_out;
   end
   // the whole sequence needs about 5000 cycles; give it six times that
   initial begin
      #600000;
      miscompares++;
      close_out;
   end
endmodule
